/* verif/sgr_host.sv */
/*
 Host model: serial master as seen at the decoded register port.
 Assumes one-cycle request pulses and the read answer one edge after the request.
*/
`timescale 1ns/10ps

module sgr_host #(
   parameter int PROG_WAIT = 4
)(
   input wire logic clock,
   output logic reg_write,
   output logic reg_read,
   output logic [6:0] reg_addr,
   output logic [31:0] reg_wdata,
   input wire logic [31:0] reg_rdata,
   input wire logic reg_rvalid
);
   initial begin
      reg_write = 1'b0;
      reg_read = 1'b0;
      reg_addr = 7'h00;
      reg_wdata = 32'h0000_0000;
   end

   // Released lines get inverted so stale values never pass
   task automatic wr(input logic [6:0] a, input logic [31:0] d);
      @(posedge clock);
      reg_write <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clock);
      reg_write <= 1'b0;
      reg_addr <= ~a;
      reg_wdata <= ~d;
   endtask

   task automatic rd(input logic [6:0] a, output logic [31:0] d);
      @(posedge clock);
      reg_read <= 1'b1;
      reg_addr <= a;
      @(posedge clock);
      reg_read <= 1'b0;
      reg_addr <= ~a;
      @(posedge clock);
      d = (reg_rvalid === 1'b1) ? reg_rdata : 32'hxxxx_xxxx;
   endtask

   // Programming time scaled down; device programs in one cycle
   task automatic prog(input logic [1:0] byte_sel, input logic [2:0] bit_idx, input logic [7:0] key);
      wr(7'h04, {16'h0000, key, 2'b00, byte_sel, 1'b0, bit_idx});
      repeat (PROG_WAIT) @(posedge clock);
   endtask
endmodule // sgr_host

/* verif/sgr_tb.sv */
/*
 Self-checking testbench of the general register bank.
 Assumes the host model drives the register port; the bench drives pins and faults.
*/
`timescale 1ns/10ps

module testbench;
   logic clock, rstn, por_n, driver_shutdown, fault_active, pump_undervolt;
   logic reg_write, reg_read, reg_rvalid, power_stage_off;
   logic [6:0] reg_addr;
   logic [31:0] reg_wdata, reg_rdata, rdv;
   logic [7:0] pins;
   logic [6:0] reply_wait_bits;
   logic [4:0] oscillator_tune;
   logic [1:0] thermal_threshold_select;
   logic [7:0] pat [3] = '{8'hff, 8'h5a, 8'ha5};
   int errors, checked;

   sgr_general_regs #(.VERSION(8'h3c)) dut_u ( // Version value arbitrary
      .clock(clock), .rstn(rstn), .por_n(por_n), .reg_write(reg_write), .reg_read(reg_read),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
      .driver_shutdown(driver_shutdown), .fault_active(fault_active), .pump_undervolt(pump_undervolt),
      .enable_low_input(pins[0]), .microstep_sel_a(pins[1]), .microstep_sel_b(pins[2]),
      .fault_indicator_pin(pins[3]), .power_down_pin(pins[4]), .step_pin(pins[5]),
      .chopper_select_pin(pins[6]), .direction_pin(pins[7]), .reply_wait_bits(reply_wait_bits),
      .oscillator_tune(oscillator_tune), .thermal_threshold_select(thermal_threshold_select),
      .power_stage_off(power_stage_off));

   sgr_host host_u (.clock(clock), .reg_write(reg_write), .reg_read(reg_read), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));

   initial begin
      clock = 1'b0;
      forever #2.5 clock = ~clock;
   end

   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      checked++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic done(input string name);
      $display("test %s finished", name);
   endtask

   task automatic wrap_up();
      $display("comparisons %0d mismatches %0d", checked, errors);
      if (errors == 0 && checked > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // Fuses survive a register reset, so por_n is optional
   task automatic do_reset(input logic with_por);
      @(posedge clock);
      rstn <= 1'b0;
      por_n <= ~with_por;
      repeat (8) @(posedge clock);
      rstn <= 1'b1;
      por_n <= 1'b1;
      repeat (2) @(posedge clock);
   endtask

   function automatic logic [31:0] pin_word(input logic [7:0] p);
      return {8'h3c, 14'h0000, p[7], p[6], p[5], p[4], 1'b0, p[3], p[2], p[1], 1'b0, p[0]};
   endfunction

   initial begin
      #50us;
      errors++;
      $display("watchdog expired");
      wrap_up();
   end

   initial begin
      rstn = 1'b0;
      por_n = 1'b0;
      driver_shutdown = 1'b0;
      fault_active = 1'b0;
      pump_undervolt = 1'b0;
      pins = 8'h00;
      errors = 0;
      checked = 0;
      do_reset(1'b1);
      host_u.rd(7'h01, rdv);
      chk("status", 32'h0000_0001, rdv);
      host_u.wr(7'h01, 32'h0000_0000);
      host_u.rd(7'h01, rdv);
      chk("status", 32'h0000_0001, rdv);
      host_u.wr(7'h01, 32'h0000_0001);
      host_u.rd(7'h01, rdv);
      chk("status", 32'h0000_0000, rdv);
      host_u.rd(7'h02, rdv);
      chk("counter", 32'h0000_0002, rdv);
      host_u.rd(7'h02, rdv);
      chk("counter", 32'h0000_0002, rdv);
      done("status and counter");
      @(posedge clock);
      fault_active <= 1'b1;
      driver_shutdown <= 1'b1;
      @(posedge clock);
      driver_shutdown <= 1'b0;
      host_u.wr(7'h01, 32'h0000_0002);
      host_u.rd(7'h01, rdv);
      chk("status", 32'h0000_0002, rdv);
      fault_active <= 1'b0;
      host_u.wr(7'h01, 32'h0000_0002);
      host_u.rd(7'h01, rdv);
      chk("status", 32'h0000_0000, rdv);
      pump_undervolt <= 1'b1;
      repeat (3) @(posedge clock);
      chk("stage off", 32'h0000_0001, {31'h0, power_stage_off});
      host_u.rd(7'h01, rdv);
      chk("status", 32'h0000_0004, rdv);
      pump_undervolt <= 1'b0;
      repeat (3) @(posedge clock);
      host_u.rd(7'h01, rdv);
      chk("status", 32'h0000_0000, rdv);
      chk("stage off", 32'h0000_0000, {31'h0, power_stage_off});
      done("faults");
      for (int i = 0; i < 256; i++) host_u.wr(7'h02, 32'h0000_00ff);
      host_u.rd(7'h02, rdv);
      chk("counter", 32'h0000_0004, rdv);
      done("counter wrap");
      for (int v = 0; v < 16; v++) begin
         host_u.wr(7'h03, 32'(v) << 8);
         #1;
         chk("reply wait", 32'((v | 1) * 8), {25'h0, reply_wait_bits});
      end
      host_u.rd(7'h03, rdv);
      chk("reply cfg", 32'h0000_0000, rdv);
      done("reply delay");
      host_u.prog(2'h0, 3'h1, 8'h12);
      host_u.prog(2'h3, 3'h2, 8'hbd);
      host_u.prog(2'h1, 3'h2, 8'hbd);
      host_u.rd(7'h05, rdv);
      chk("fuse copy", 32'h0000_0000, rdv);
      host_u.rd(7'h04, rdv);
      chk("prog reg", 32'h0000_0000, rdv);
      host_u.rd(7'h05, rdv);
      chk("fuse copy", 32'h0000_0400, rdv);
      host_u.prog(2'h2, 3'h7, 8'hbd);
      host_u.prog(2'h0, 3'h0, 8'hbd);
      host_u.prog(2'h0, 3'h6, 8'hbd);
      host_u.prog(2'h1, 3'h2, 8'hbd);
      host_u.rd(7'h04, rdv);
      host_u.rd(7'h05, rdv);
      chk("fuse copy", 32'h0080_0441, rdv);
      done("fuses");
      do_reset(1'b0);
      host_u.rd(7'h07, rdv);
      chk("trim", 32'h0000_0201, rdv);
      host_u.rd(7'h05, rdv);
      chk("fuse copy", 32'h0080_0441, rdv);
      host_u.rd(7'h01, rdv);
      chk("status", 32'h0000_0001, rdv);
      host_u.rd(7'h02, rdv);
      chk("counter", 32'h0000_0000, rdv);
      host_u.wr(7'h05, 32'h0000_0000);
      host_u.rd(7'h05, rdv);
      chk("fuse copy", 32'h0080_0441, rdv);
      for (int t = 0; t < 4; t++) begin
         host_u.wr(7'h07, (32'(t) << 8) | 32'(t * 9 + 3));
         #1;
         chk("thermal", 32'(t), {30'h0, thermal_threshold_select});
         chk("tune", 32'(t * 9 + 3), {27'h0, oscillator_tune});
         host_u.rd(7'h07, rdv);
         chk("trim", (32'(t) << 8) | 32'(t * 9 + 3), rdv);
      end
      done("trims");
      foreach (pat[k]) begin
         pins <= pat[k];
         host_u.wr(7'h06, 32'hffff_ffff);
         host_u.rd(7'h06, rdv);
         chk("pins", pin_word(pat[k]), rdv);
      end
      host_u.rd(7'h1f, rdv);
      chk("unmapped", 32'h0000_0000, rdv);
      done("pins");
      wrap_up();
   end
endmodule // testbench

/* verilog/sgr_fuse_array.sv */
/*
 Three one-time-programmable bytes held in flip-flops, set one bit per strobe.
 Assumes por_n is a power-on reset only; register resets must not wipe it.
*/
`timescale 1ns/10ps
`include "sgr_params.svh"

module sgr_fuse_array
   import sgr_pkg::*;
#(
   parameter logic [23:0] FUSE_INIT = 24'h00_0000
)(
   input wire logic clock,
   input wire logic por_n,
   input wire logic program_strobe,
   input wire logic [1:0] byte_select,
   input wire logic [2:0] bit_index,
   output logic [23:0] fuse_bits
);

   logic [23:0] state;
   logic [23:0] next_state;

   always_comb begin
      next_state = state;
      // Only OR-in: a blown bit never returns to zero; byte 3 does not exist
      if (program_strobe && byte_select <= `SGR_LAST_FUSE_BYTE) begin
         next_state[{byte_select, bit_index}] = 1'b1;
      end
   end

   always_ff @(posedge clock or negedge por_n) begin
      if (!por_n) begin
         state <= FUSE_INIT;
      end else begin
         state <= next_state;
      end
   end

   assign fuse_bits = state;

endmodule // sgr_fuse_array

/* verilog/sgr_general_regs.sv */
/*
 General configuration and status register bank of the motor driver.
 Assumes a serial frame decoder upstream that issues one-cycle reg_write
 pulses only for frames that passed all checks, and one-cycle reg_read pulses.
*/
// How it works
// - Writing one to status bit 0 or 1 clears it; zero leaves it; bit 2 follows its input.
// - Status bit 0 is set by reset; all registers take reset values.
// - Status bit 1 latches when the power stage is shut down by a fault.
// - Fault flag clear only takes effect once all fault causes are gone.
// - Eight-bit counter steps once per successful write access.
// - Reads leave the counter alone; it wraps from 255 to 0.
// - Reply delay field bits 11..8 gives (value or one) times eight bit times.
// - Programming write sets bit n of the chosen fuse byte to one.
// - Byte select bits 5..4; only bytes 0, 1 and 2 are programmable.
// - Programming happens only with key 0xbd in bits 15..8.
// - Reading the programming register reloads the readback copy from fuses.
// - Readback register shows fuse bytes 0, 1, 2 in ascending byte lanes.
// - Input register shows live pin levels; bits 1 and 5 read zero.
// - Bits 31..24 of input register hold a fixed silicon version code.
// - Oscillator tune bits 4..0 load their reset value from the fuses.
// - Thermal threshold select bits 9..8 load their default from the fuses.
// - Fuse bits start at zero and can only be changed to one.
`timescale 1ns/10ps
`include "sgr_params.svh"

module sgr_general_regs
   import sgr_pkg::*;
#(
   parameter logic [7:0] VERSION = 8'h5a, // Arbitrary value
   parameter logic [23:0] FUSE_INIT = 24'h00_0000,
   parameter int FUSE_BYTES = 3
)(
   input wire logic clock,
   input wire logic rstn,
   input wire logic por_n,
   input wire logic reg_write,
   input wire logic reg_read,
   input wire logic [6:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   output logic [31:0] reg_rdata,
   output logic reg_rvalid,
   input wire logic driver_shutdown,
   input wire logic fault_active,
   input wire logic pump_undervolt,
   input wire logic enable_low_input,
   input wire logic microstep_sel_a,
   input wire logic microstep_sel_b,
   input wire logic fault_indicator_pin,
   input wire logic power_down_pin,
   input wire logic step_pin,
   input wire logic chopper_select_pin,
   input wire logic direction_pin,
   output logic [6:0] reply_wait_bits,
   output logic [4:0] oscillator_tune,
   output logic [1:0] thermal_threshold_select,
   output logic power_stage_off
);

   if (FUSE_BYTES != 3) begin : bad_fuse_bytes
      $error("sgr_general_regs: readback layout serves exactly three fuse bytes");
   end

   sgr_bank_t state;
   sgr_bank_t next_state;
   sgr_flag_t flags;
   logic [23:0] fuse_bits;
   logic [2:0] clear_mask;
   logic program_strobe;
   logic [9:0] pin_bits;

   function automatic logic hit(input logic [6:0] addr, input logic [6:0] ofs);
      hit = (addr == ofs);
   endfunction

   // W1C strobe goes straight to the flag keeper
   assign clear_mask = (reg_write && hit(reg_addr, `SGR_OFS_STATUS)) ? reg_wdata[2:0] : 3'h0;

   assign program_strobe = reg_write && hit(reg_addr, `SGR_OFS_PROG)
      && reg_wdata[`SGR_PROG_KEY_MSB:`SGR_PROG_KEY_LSB] == `SGR_UNLOCK_KEY;

   // Live pins; bits 1 and 5 are unused and read zero
   assign pin_bits = {direction_pin, chopper_select_pin, step_pin, power_down_pin,
      1'b0, fault_indicator_pin, microstep_sel_b, microstep_sel_a, 1'b0, enable_low_input};

   sgr_status_flags u_flags (
      .clock(clock),
      .rstn(rstn),
      .clear_mask(clear_mask),
      .driver_shutdown(driver_shutdown),
      .fault_active(fault_active),
      .pump_undervolt(pump_undervolt),
      .flags(flags)
   );

   sgr_fuse_array #(
      .FUSE_INIT(FUSE_INIT)
   ) u_fuses (
      .clock(clock),
      .por_n(por_n),
      .program_strobe(program_strobe),
      .byte_select(reg_wdata[`SGR_PROG_BYTE_MSB:`SGR_PROG_BYTE_LSB]),
      .bit_index(reg_wdata[`SGR_PROG_BIT_MSB:`SGR_PROG_BIT_LSB]),
      .fuse_bits(fuse_bits)
   );

   always_comb begin
      next_state = state;
      next_state.rvalid = reg_read;

      // Trims cannot take fuse values under async reset, so copy one edge later
      if (!state.trim_loaded) begin
         next_state.trim_loaded = 1'b1;
         next_state.fuse_readback = fuse_bits;
         next_state.oscillator_tune = fuse_bits[`SGR_TUNE_MSB:`SGR_TUNE_LSB];
         next_state.thermal_threshold_select = fuse_bits[`SGR_FUSE_THERM_MSB:`SGR_FUSE_THERM_LSB];
      end

      if (reg_write) begin
         next_state.write_count = state.write_count + 8'h01;
         case (reg_addr)
            `SGR_OFS_REPLY: begin
               next_state.reply_wait_field = reg_wdata[`SGR_REPLY_MSB:`SGR_REPLY_LSB];
            end
            `SGR_OFS_TRIM: begin
               next_state.oscillator_tune = reg_wdata[`SGR_TUNE_MSB:`SGR_TUNE_LSB];
               next_state.thermal_threshold_select = reg_wdata[`SGR_THERM_MSB:`SGR_THERM_LSB];
            end
            default: begin
               // Read-only and unmapped words store nothing; the counter still steps
               next_state.write_count = state.write_count + 8'h01;
            end
         endcase
      end

      next_state.reply_wait_bits = sgr_wait_bits(next_state.reply_wait_field);
      next_state.power_stage_off = flags.pump_undervolt_flag | flags.drv_fault;

      if (reg_read) begin
         case (reg_addr)
            `SGR_OFS_STATUS: begin
               next_state.rdata = {29'h0, flags};
            end
            `SGR_OFS_COUNT: begin
               next_state.rdata = {24'h0, state.write_count};
            end
            `SGR_OFS_PROG: begin
               next_state.rdata = 32'h0000_0000;
               next_state.fuse_readback = fuse_bits;
            end
            `SGR_OFS_READBACK: begin
               next_state.rdata = {8'h00, state.fuse_readback};
            end
            `SGR_OFS_PINS: begin
               next_state.rdata = {VERSION, 14'h0, pin_bits};
            end
            `SGR_OFS_TRIM: begin
               next_state.rdata = {22'h0, state.thermal_threshold_select, 3'h0, state.oscillator_tune};
            end
            default: begin
               next_state.rdata = 32'h0000_0000;
            end
         endcase
      end
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         // Every bank register back to its reset value
         state.write_count <= `SGR_COUNT_RESET;
         state.reply_wait_field <= `SGR_REPLY_RESET;
         state.oscillator_tune <= 5'h00;
         state.thermal_threshold_select <= 2'h0;
         state.trim_loaded <= 1'b0;
         state.fuse_readback <= 24'h00_0000;
         state.reply_wait_bits <= 7'h08;
         state.power_stage_off <= 1'b1;
         state.rdata <= 32'h0000_0000;
         state.rvalid <= 1'b0;
      end else begin
         state <= next_state;
      end
   end

   assign reg_rdata = state.rdata;
   assign reg_rvalid = state.rvalid;
   assign reply_wait_bits = state.reply_wait_bits;
   assign oscillator_tune = state.oscillator_tune;
   assign thermal_threshold_select = state.thermal_threshold_select;
   assign power_stage_off = state.power_stage_off;

   default clocking cb @(posedge clock); endclocking
   default disable iff (!rstn);

   count_step_a: assert property (reg_write |=> state.write_count == $past(state.write_count) + 8'h01)
      else $error("write counter did not step on a write");

   count_hold_a: assert property (!reg_write |=> $stable(state.write_count))
      else $error("write counter moved without a write");

   read_answer_a: assert property (reg_read |=> reg_rvalid ##1 (reg_rvalid == $past(reg_read)))
      else $error("read answer not one cycle after request");

   wo_reads_zero_a: assert property (reg_read
      && (hit(reg_addr, `SGR_OFS_REPLY) || hit(reg_addr, `SGR_OFS_PROG))
      |=> reg_rdata == 32'h0000_0000)
      else $error("write-only register read back nonzero");

   reply_delay_a: assert property (reg_write && hit(reg_addr, `SGR_OFS_REPLY)
      |=> reply_wait_bits == {3'h0, $past(reg_wdata[11:8]) | 4'h1} << 3)
      else $error("reply delay not decoded from written field");

   fault_hold_a: assert property (flags.drv_fault && fault_active && reg_write
      && hit(reg_addr, `SGR_OFS_STATUS) |=> flags.drv_fault)
      else $error("fault flag cleared while a cause persists");

   fault_latch_a: assert property (driver_shutdown
      |=> flags.drv_fault [*2] or (flags.drv_fault ##1 !fault_active))
      else $error("fault flag not latched after shutdown");

   pump_live_a: assert property (pump_undervolt |=> flags.pump_undervolt_flag ##1 power_stage_off)
      else $error("undervoltage not shown or stage not off");

   fuse_monotone_a: assert property (($past(fuse_bits) & ~fuse_bits) == 24'h00_0000)
      else $error("a fuse bit went back to zero");

   key_guard_a: assert property (reg_write && hit(reg_addr, `SGR_OFS_PROG) && reg_wdata[15:8] != 8'hbd
      |=> $stable(fuse_bits))
      else $error("fuses changed without the unlock key");

   reload_a: assert property (reg_read && hit(reg_addr, `SGR_OFS_PROG)
      |=> state.fuse_readback == $past(fuse_bits))
      else $error("readback copy not refreshed by programming register read");

   pins_view_a: assert property (reg_read && hit(reg_addr, `SGR_OFS_PINS)
      |=> reg_rdata[31:24] == VERSION && reg_rdata[1] == 1'b0 && reg_rdata[5] == 1'b0)
      else $error("input register layout wrong");

   ro_write_a: assert property (reg_write && hit(reg_addr, `SGR_OFS_READBACK) && state.trim_loaded
      && !reg_read |=> $stable(state.fuse_readback))
      else $error("read-only readback changed on a write");

   // Release edge still shows reset values, so checks against it wait for rstn
   status_clear_a: assert property (reg_write && hit(reg_addr, `SGR_OFS_STATUS) && reg_wdata[0]
      |=> !flags.reset_seen)
      else $error("reset flag not cleared by a one");

   status_read_a: assert property (reg_read && hit(reg_addr, `SGR_OFS_STATUS)
      |=> reg_rdata[31:3] == 29'h0000_0000 && reg_rdata[2:0] == $past(flags))
      else $error("status word not read as the flags");

   reset_hold_a: assert property (flags.reset_seen
      && !(reg_write && hit(reg_addr, `SGR_OFS_STATUS) && reg_wdata[0]) |=> flags.reset_seen)
      else $error("reset flag dropped without a clear");

   fault_clear_a: assert property (flags.drv_fault && !fault_active && !driver_shutdown
      && reg_write && hit(reg_addr, `SGR_OFS_STATUS) && reg_wdata[1] |=> !flags.drv_fault)
      else $error("fault flag not cleared once causes were gone");

   stage_off_a: assert property (flags.drv_fault || flags.pump_undervolt_flag |=> power_stage_off)
      else $error("power stage not held off");

   stage_on_a: assert property (rstn && !flags.drv_fault && !flags.pump_undervolt_flag
      |=> !power_stage_off)
      else $error("power stage held off without a cause");

   // Fuse checks; a power-on reset alone would need its own disable
   prog_bit_a: assert property (program_strobe && reg_wdata[5:4] != 2'h3
      |=> fuse_bits[$past({reg_wdata[5:4], reg_wdata[2:0]})])
      else $error("programming write did not set the chosen fuse bit");

   byte_guard_a: assert property (reg_write && hit(reg_addr, `SGR_OFS_PROG) && reg_wdata[5:4] == 2'h3
      |=> $stable(fuse_bits))
      else $error("fuses changed for a byte that does not exist");

   readback_lanes_a: assert property (reg_read && hit(reg_addr, `SGR_OFS_READBACK)
      |=> reg_rdata[31:24] == 8'h00 && reg_rdata[23:0] == $past(state.fuse_readback))
      else $error("readback word not in byte order");

   pins_live_a: assert property (reg_read && hit(reg_addr, `SGR_OFS_PINS)
      |=> reg_rdata[0] == $past(enable_low_input) && reg_rdata[4] == $past(fault_indicator_pin)
      && reg_rdata[9] == $past(direction_pin))
      else $error("input register does not show the pins");

   trim_load_a: assert property (rstn && !state.trim_loaded && !reg_write
      |=> oscillator_tune == $past(fuse_bits[4:0]) && thermal_threshold_select == $past(fuse_bits[6:5]))
      else $error("trims not loaded from the fuses after reset");

   trim_write_a: assert property (reg_write && hit(reg_addr, `SGR_OFS_TRIM)
      |=> oscillator_tune == $past(reg_wdata[4:0]) && thermal_threshold_select == $past(reg_wdata[9:8]))
      else $error("trims not taken from the written word");

   rvalid_idle_a: assert property (!reg_read |=> !reg_rvalid)
      else $error("read answer without a request");

   reply_keep_a: assert property (!(reg_write && hit(reg_addr, `SGR_OFS_REPLY))
      |=> $stable(reply_wait_bits))
      else $error("reply delay moved without a write");

endmodule // sgr_general_regs

/* verilog/sgr_params.svh */
/*
 Offsets, field positions, reset values and key codes of the general register bank.
 Assumes the includer uses 7-bit register addresses and 32-bit data words.
*/
`ifndef SGR_PARAMS_SVH
`define SGR_PARAMS_SVH

`define SGR_ADDR_W 7
`define SGR_DATA_W 32

`define SGR_OFS_STATUS 7'h01
`define SGR_OFS_COUNT 7'h02
`define SGR_OFS_REPLY 7'h03
`define SGR_OFS_PROG 7'h04
`define SGR_OFS_READBACK 7'h05
`define SGR_OFS_PINS 7'h06
`define SGR_OFS_TRIM 7'h07

`define SGR_STATUS_RESET_BIT 0
`define SGR_STATUS_FAULT_BIT 1
`define SGR_STATUS_PUMP_BIT 2

`define SGR_REPLY_LSB 8
`define SGR_REPLY_MSB 11
`define SGR_PROG_BIT_LSB 0
`define SGR_PROG_BIT_MSB 2
`define SGR_PROG_BYTE_LSB 4
`define SGR_PROG_BYTE_MSB 5
`define SGR_PROG_KEY_LSB 8
`define SGR_PROG_KEY_MSB 15
`define SGR_UNLOCK_KEY 8'hbd
`define SGR_LAST_FUSE_BYTE 2'h2

`define SGR_TUNE_LSB 0
`define SGR_TUNE_MSB 4
`define SGR_THERM_LSB 8
`define SGR_THERM_MSB 9
`define SGR_FUSE_THERM_LSB 5
`define SGR_FUSE_THERM_MSB 6
`define SGR_VERSION_LSB 24

`define SGR_COUNT_RESET 8'h00
`define SGR_REPLY_RESET 4'h0
`define SGR_STATUS_RESET 3'h1

`endif

/* verilog/sgr_pkg.sv */
/*
 Types shared by the general register bank and its two helper modules.
 Assumes sgr_params.svh is on the include path.
*/
`include "sgr_params.svh"

package sgr_pkg;

   typedef struct packed {
      logic pump_undervolt_flag;
      logic drv_fault;
      logic reset_seen;
   } sgr_flag_t;

   typedef struct packed {
      logic [7:0] write_count;
      logic [3:0] reply_wait_field;
      logic [4:0] oscillator_tune;
      logic [1:0] thermal_threshold_select;
      logic trim_loaded;
      logic [23:0] fuse_readback;
      logic [6:0] reply_wait_bits;
      logic power_stage_off;
      logic [31:0] rdata;
      logic rvalid;
   } sgr_bank_t;

   // Pairs of codes share one delay: odd value times eight bit times
   function automatic logic [6:0] sgr_wait_bits(input logic [3:0] field);
      sgr_wait_bits = {3'h0, field | 4'h1} << 3;
   endfunction

endpackage

/* verilog/sgr_status_flags.sv */
/*
 Global status flags: reset seen, latched driver fault, live pump undervoltage.
 Assumes clear mask is a one-cycle write strobe already qualified by address.
*/
`timescale 1ns/10ps
`include "sgr_params.svh"

module sgr_status_flags
   import sgr_pkg::*;
(
   input wire logic clock,
   input wire logic rstn,
   input wire logic [2:0] clear_mask,
   input wire logic driver_shutdown,
   input wire logic fault_active,
   input wire logic pump_undervolt,
   output sgr_flag_t flags
);

   sgr_flag_t state;
   sgr_flag_t next_state;

   always_comb begin
      next_state = state;
      if (clear_mask[`SGR_STATUS_RESET_BIT]) begin
         next_state.reset_seen = 1'b0;
      end
      // Clear refused while any fault cause remains; new shutdown beats clear
      if (clear_mask[`SGR_STATUS_FAULT_BIT] && !fault_active) begin
         next_state.drv_fault = 1'b0;
      end
      if (driver_shutdown) begin
         next_state.drv_fault = 1'b1;
      end
      next_state.pump_undervolt_flag = pump_undervolt;
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         state <= `SGR_STATUS_RESET;
      end else begin
         state <= next_state;
      end
   end

   assign flags = state;

endmodule // sgr_status_flags
